// file: inc/reset_cause_pkg.sv
// Constants for the reset cause and status register block.
// Assumes a 32-bit classic Wishbone bus and a single system clock.
`default_nettype none

package reset_cause_pkg;

    // Bus shape
    localparam int DATA_W = 32;
    localparam int ADR_W = 8;
    localparam int SEL_W = 4;
    localparam int STAT_W = 16;

    // Register map
    localparam logic [7:0] STATUS_OFFSET = 8'h00;

    // Field positions inside the status register
    localparam int TRAP_BIT = 15;
    localparam int ILLEGAL_BIT = 14;
    localparam int FLASH_REG_BIT = 11;
    localparam int MISMATCH_BIT = 9;
    localparam int MAIN_REG_BIT = 8;
    localparam int PIN_BIT = 7;
    localparam int SOFT_RST_BIT = 6;
    localparam int WDT_EN_BIT = 5;
    localparam int WDT_TO_BIT = 4;
    localparam int SLEEP_BIT = 3;
    localparam int IDLE_BIT = 2;
    localparam int BROWNOUT_BIT = 1;
    localparam int POWER_ON_BIT = 0;

    // Power-on value and the set of bits that exist
    localparam logic [15:0] POR_VALUE = 16'h0003;
    localparam logic [15:0] IMPL_MASK = 16'hCBFF;

    // Unprogrammed watchdog configuration forces the watchdog on
    localparam logic [1:0] WDT_CFG_UNPROG = 2'h3;

endpackage

`default_nettype wire

// file: rtl/reset_cause_status.sv
// Reset cause and status register with a classic Wishbone slave port.
// Assumes reset event inputs come from logic on clk_in, except the
// master clear pin, which is asynchronous and is synchronised here.
`default_nettype none
`timescale 1ns/100ps

module reset_cause_status (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [reset_cause_pkg::ADR_W-1:0] wb_adr_in,
    input wire logic [reset_cause_pkg::SEL_W-1:0] wb_sel_in,
    input wire logic [reset_cause_pkg::DATA_W-1:0] wb_dat_in,
    output logic [reset_cause_pkg::DATA_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic trap_conflict_reset_in,
    input wire logic illegal_op_reset_in,
    input wire logic config_mismatch_reset_in,
    input wire logic master_clear_pin_n_in,
    input wire logic software_reset_in,
    input wire logic watchdog_timeout_in,
    input wire logic sleep_wake_in,
    input wire logic idle_wake_in,
    input wire logic brownout_reset_in,
    input wire logic [1:0] watchdog_config_enable_in,
    output logic watchdog_enable_out,
    output logic flash_regulator_sleep_active_out,
    output logic main_regulator_sleep_active_out,
    output logic system_reset_out
);
    import reset_cause_pkg::*;

    logic [STAT_W-1:0] reset_cause_status;
    logic [STAT_W-1:0] next_status;
    logic pin_meta;
    logic pin_sync_n;
    logic seen_run;

    ////////////////////////////////////////////////////////////////////
    // Master clear pin synchroniser, two stages before any use.
    // Both stages rest high, the idle level of the pin, so leaving
    // reset never shows a false pin reset. A pulse shorter than one
    // clock may be missed; the pin is meant to be held for many cycles.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_meta <= 1'b1;
            pin_sync_n <= 1'b1;
        end else begin
            pin_meta <= master_clear_pin_n_in;
            pin_sync_n <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    wire bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire hit = (wb_adr_in == STATUS_OFFSET);
    wire wr_take = bus_req && wb_we_in && hit;
    wire rd_take = bus_req && !wb_we_in && hit;
    // Lanes 2 and 3 and the upper data half are ignored on purpose, so a
    // full-word store from software lands the same as a half-word one
    // Byte lanes 0 and 1 carry the register; unimplemented bits masked
    wire [STAT_W-1:0] lane_mask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    wire [STAT_W-1:0] wr_mask = lane_mask & IMPL_MASK;
    wire [STAT_W-1:0] wr_val = wb_dat_in[STAT_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // Hardware events, one bit per flag
    wire pin_reset = !pin_sync_n;
    wire [STAT_W-1:0] ev_bits = {
        trap_conflict_reset_in,
        illegal_op_reset_in,
        4'h0,
        config_mismatch_reset_in,
        1'b0,
        pin_reset,
        software_reset_in,
        1'b0,
        watchdog_timeout_in,
        sleep_wake_in,
        idle_wake_in,
        brownout_reset_in,
        1'b0
    };
    // Sources that pull the system reset; sleep and idle do not
    wire any_reset = trap_conflict_reset_in || illegal_op_reset_in
        || config_mismatch_reset_in || pin_reset || software_reset_in
        || watchdog_timeout_in || brownout_reset_in;

    ////////////////////////////////////////////////////////////////////
    // Next value: the write lands first, then events OR in on top, so
    // an event in the very cycle of a clearing write is never lost
    wire [STAT_W-1:0] after_wr = (reset_cause_status & ~wr_mask)
        | (wr_val & wr_mask);
    always_comb begin
        next_status = wr_take ? after_wr : reset_cause_status;
        next_status = (next_status | ev_bits) & IMPL_MASK;
    end

    // Besides a write, only power-on, the async reset, clears older flags; it also sets
    // the power-on and brown-out flags in bits 0 and 1
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reset_cause_status <= POR_VALUE;
        end else begin
            reset_cause_status <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus answer: one cycle after the request, unmapped reads give zero
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end else begin
            wb_ack_out <= bus_req;
            if (rd_take) begin
                wb_dat_out <= {16'h0000, reset_cause_status};
            end else begin
                wb_dat_out <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // System reset request comes only from real events, never from
    // software writing a flag, so a stray write cannot reset the chip
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            system_reset_out <= 1'b0;
            seen_run <= 1'b0;
        end else begin
            system_reset_out <= any_reset;
            seen_run <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control outputs driven from register bits. The configuration
    // override is combinational, so the watchdog is forced on from the
    // first cycle without waiting for a register update.
    wire wdt_forced = (watchdog_config_enable_in == WDT_CFG_UNPROG);
    assign watchdog_enable_out = reset_cause_status[WDT_EN_BIT]
        || wdt_forced;
    assign flash_regulator_sleep_active_out =
        reset_cause_status[FLASH_REG_BIT];
    assign main_regulator_sleep_active_out =
        reset_cause_status[MAIN_REG_BIT];

    ////////////////////////////////////////////////////////////////////
    // Checks on the flags and the bus
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // Event flags: each source must show up in the register one cycle
    // after it is seen, whatever the bus does in the same cycle

    trap_flag_a: assert property (
        trap_conflict_reset_in |=> reset_cause_status[TRAP_BIT])
        else $error("trap flag not set");
    illegal_flag_a: assert property (
        illegal_op_reset_in |=> reset_cause_status[ILLEGAL_BIT])
        else $error("illegal op flag not set");

    // Bus view of the unimplemented bits and the control bits
    unimpl_zero_a: assert property (
        wb_ack_out |-> wb_dat_out[13:12] == 2'h0 && !wb_dat_out[10])
        else $error("unimplemented bits read nonzero");
    flash_reg_a: assert property (
        wr_take && wb_sel_in[1] && !any_reset
        |=> flash_regulator_sleep_active_out == $past(wb_dat_in[11]))
        else $error("flash regulator bit not written");
    mismatch_flag_a: assert property (
        config_mismatch_reset_in |=> reset_cause_status[MISMATCH_BIT])
        else $error("mismatch flag not set");
    main_reg_a: assert property (
        wr_take && wb_sel_in[1]
        |=> main_regulator_sleep_active_out == $past(wb_dat_in[8]))
        else $error("main regulator bit not written");

    // Pin flag: three low samples cover the two synchroniser stages
    pin_flag_a: assert property (
        !master_clear_pin_n_in [*3] |=> reset_cause_status[PIN_BIT])
        else $error("pin flag not set after sync");
    soft_flag_a: assert property (
        software_reset_in |=> reset_cause_status[SOFT_RST_BIT])
        else $error("software reset flag not set");

    // Watchdog enable, by software or by the configuration override
    wdt_soft_a: assert property (
        wr_take && wb_sel_in[0] && !wdt_forced
        ##1 !wdt_forced |-> watchdog_enable_out == $past(wb_dat_in[5]))
        else $error("watchdog enable does not follow write");
    wdt_forced_a: assert property (
        wdt_forced |-> watchdog_enable_out)
        else $error("watchdog off while forced");
    wdt_flag_a: assert property (
        watchdog_timeout_in |=> reset_cause_status[WDT_TO_BIT])
        else $error("watchdog timeout flag not set");
    sleep_flag_a: assert property (
        sleep_wake_in |=> reset_cause_status[SLEEP_BIT])
        else $error("sleep flag not set");
    idle_flag_a: assert property (
        idle_wake_in |=> reset_cause_status[IDLE_BIT])
        else $error("idle flag not set");
    brownout_flag_a: assert property (
        brownout_reset_in |=> reset_cause_status[BROWNOUT_BIT])
        else $error("brownout flag not set");

    // Power-on value and software stores
    por_value_a: assert property (
        !seen_run |-> reset_cause_status == POR_VALUE)
        else $error("wrong value after power-on");
    write_store_a: assert property (
        wr_take && ev_bits == 16'h0000 |=> ((reset_cause_status
        ^ $past(wr_val)) & $past(wr_mask)) == 16'h0000)
        else $error("write not stored");

    // System reset request and flag history
    no_soft_reset_a: assert property (
        wr_take && !any_reset |=> !system_reset_out)
        else $error("write caused a system reset");
    reset_out_a: assert property (
        any_reset |=> system_reset_out)
        else $error("reset event not forwarded");
    keep_flags_a: assert property (
        !wr_take |=> (reset_cause_status & $past(reset_cause_status))
        == $past(reset_cause_status))
        else $error("older flag lost");
    bus_ack_a: assert property (
        bus_req |=> wb_ack_out ##1 !wb_ack_out)
        else $error("ack not a single cycle");

    ////////////////////////////////////////////////////////////////////
    // Read path: the answer carries the register as it stood at the
    // taking edge, and the data lines rest at zero between answers
    read_data_a: assert property (
        rd_take |=> wb_dat_out == {16'h0000, $past(reset_cause_status)})
        else $error("read data differs from register");

    upper_zero_a: assert property (
        wb_dat_out[31:16] == 16'h0000)
        else $error("upper half of read word nonzero");

    idle_data_a: assert property (
        !wb_ack_out |-> wb_dat_out == 32'h0000_0000)
        else $error("read data not zero between answers");

    unmapped_zero_a: assert property (
        bus_req && !hit |=> wb_dat_out == 32'h0000_0000)
        else $error("unmapped read not zero");

    ack_cause_a: assert property (
        wb_ack_out |-> $past(bus_req))
        else $error("ack without a request");

    ack_single_a: assert property (
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");

    ////////////////////////////////////////////////////////////////////
    // Storage: unimplemented bits stay clear, and nothing but a write
    // or an event may move a stored bit
    unimpl_store_a: assert property (
        (reset_cause_status & ~IMPL_MASK) == 16'h0000)
        else $error("unimplemented bit stored");

    hold_value_a: assert property (
        !wr_take && ev_bits == 16'h0000 |=> $stable(reset_cause_status))
        else $error("register changed with no cause");

    unmapped_write_a: assert property (
        bus_req && wb_we_in && !hit && ev_bits == 16'h0000
        |=> $stable(reset_cause_status))
        else $error("unmapped write changed the register");

    no_lane_a: assert property (
        wr_take && wb_sel_in[1:0] == 2'h0 && ev_bits == 16'h0000
        |=> $stable(reset_cause_status))
        else $error("write with no lane changed the register");

    por_flag_hold_a: assert property (
        !wr_take |=> reset_cause_status[POWER_ON_BIT]
        == $past(reset_cause_status[POWER_ON_BIT]))
        else $error("power-on flag moved without a write");

    ctrl_hold_a: assert property (
        !wr_take |=> $stable(reset_cause_status[FLASH_REG_BIT])
        && $stable(reset_cause_status[MAIN_REG_BIT])
        && $stable(reset_cause_status[WDT_EN_BIT]))
        else $error("control bit moved without a write");

    ////////////////////////////////////////////////////////////////////
    // Byte lanes: a write on one lane leaves the other lane untouched
    lane_high_a: assert property (
        wr_take && wb_sel_in[1:0] == 2'h2 && ev_bits == 16'h0000
        |=> reset_cause_status[7:0] == $past(reset_cause_status[7:0]))
        else $error("high lane write touched low byte");

    lane_low_a: assert property (
        wr_take && wb_sel_in[1:0] == 2'h1 && ev_bits == 16'h0000
        |=> reset_cause_status[15:8] == $past(reset_cause_status[15:8]))
        else $error("low lane write touched high byte");

    clear_write_a: assert property (
        wr_take && wb_sel_in[1:0] == 2'h3 && wr_val == 16'h0000
        && ev_bits == 16'h0000 |=> reset_cause_status == 16'h0000)
        else $error("full clearing write left a bit set");

    set_write_a: assert property (
        wr_take && wb_sel_in[1:0] == 2'h3 && wr_val == 16'hFFFF
        && ev_bits == 16'h0000
        |=> reset_cause_status == IMPL_MASK && !system_reset_out)
        else $error("full setting write wrong or caused a reset");

    ////////////////////////////////////////////////////////////////////
    // Events: a set in the cycle of a clearing write must survive, and
    // only true reset events may pull the system reset
    set_wins_a: assert property (
        wr_take && ev_bits != 16'h0000
        |=> (reset_cause_status & $past(ev_bits)) == $past(ev_bits))
        else $error("event lost to a clearing write");

    reset_cause_a: assert property (
        !any_reset |=> !system_reset_out)
        else $error("system reset without a reset event");

    pin_sync_a: assert property (
        !pin_sync_n |=> reset_cause_status[PIN_BIT] && system_reset_out)
        else $error("synchronised pin reset not recorded");

    wake_only_a: assert property (
        (sleep_wake_in || idle_wake_in) && !any_reset
        |=> !system_reset_out)
        else $error("wake event pulled the system reset");


    // Main scenarios: read, clearing write, write racing an event,
    // forced watchdog and a pin reset reaching its flag
    read_cover_c: cover property (rd_take ##1 wb_ack_out);
    pin_cover_c: cover property (pin_reset ##1 reset_cause_status[PIN_BIT]);
    clear_cover_c: cover property (wr_take && (wr_val & wr_mask) == 16'h0000);
    race_cover_c: cover property (wr_take && any_reset);
    forced_cover_c: cover property (wdt_forced && !reset_cause_status[5]);

endmodule

`default_nettype wire

// file: verification/tb_reset_cause_status.sv
// Self-checking bench for the reset cause and status register.
// Assumes the package and the design are compiled before this file.
`timescale 1ns/100ps
`default_nettype none

module tb_reset_cause_status;
    import reset_cause_pkg::*;

    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack, wdt_en, flash_act, main_act, sys_rst;
    logic [7:0] ev = 8'h00;
    logic pin_n = 1'b1;
    logic [1:0] wcfg = 2'h0;
    logic [31:0] q, acc;
    logic is_rst;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    // Flag positions of the event inputs, in the order of ev
    int bit_pos [8] = '{15, 14, 9, 6, 4, 3, 2, 1};

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and hang guard
    always #50 clk_in = ~clk_in;

    reset_cause_status reset_cause_status_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack),
        .trap_conflict_reset_in(ev[0]), .illegal_op_reset_in(ev[1]),
        .config_mismatch_reset_in(ev[2]), .software_reset_in(ev[3]),
        .watchdog_timeout_in(ev[4]), .sleep_wake_in(ev[5]),
        .idle_wake_in(ev[6]), .brownout_reset_in(ev[7]),
        .master_clear_pin_n_in(pin_n), .watchdog_config_enable_in(wcfg),
        .watchdog_enable_out(wdt_en),
        .flash_regulator_sleep_active_out(flash_act),
        .main_regulator_sleep_active_out(main_act),
        .system_reset_out(sys_rst));

    // The whole run needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic cycle; waits for ack under a bound, data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int k;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (ack !== 1'b1 && k < 20);
        check("ack", {31'h0000_0000, ack}, 32'h0000_0001);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
        check("por value", q, 32'h0000_0003);
        wb(1'b1, 8'h00, 4'hF, 32'hFFFF_FFFF);
        check("write sysrst", {31'h0, sys_rst}, 32'h0);
        wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
        check("all ones", q, 32'h0000_CBFF);
        check("flash reg", {31'h0, flash_act}, 32'h1);
        check("main reg", {31'h0, main_act}, 32'h1);
        check("wdt on", {31'h0, wdt_en}, 32'h1);
        // Low byte only: upper flags must survive
        wb(1'b1, 8'h00, 4'h1, 32'h0000_0000);
        wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
        check("byte write", q, 32'h0000_CB00);
        wb(1'b1, 8'h00, 4'h3, 32'h0000_0000);
        wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
        check("cleared", q, 32'h0000_0000);
        check("flash off", {31'h0, flash_act}, 32'h0);
        check("main off", {31'h0, main_act}, 32'h0);
        check("wdt off", {31'h0, wdt_en}, 32'h0);
        wcfg <= WDT_CFG_UNPROG;
        @(posedge clk_in);
        #1 check("wdt forced", {31'h0, wdt_en}, 32'h1);
        @(posedge clk_in);
        wcfg <= 2'h0;
        // Unmapped place: acked, reads zero, write lost
        wb(1'b1, 8'h04, 4'hF, 32'hFFFF_FFFF);
        wb(1'b0, 8'h04, 4'hF, 32'h0000_0000);
        check("unmapped", q, 32'h0000_0000);
        wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
        check("still clear", q, 32'h0000_0000);
        // Each event adds its own flag and keeps older ones
        acc = 32'h0000_0000;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            ev <= 8'h01 << i;
            @(posedge clk_in);
            ev <= 8'h00;
            is_rst = !(i == 5 || i == 6);
            #1 check("sysrst", {31'h0, sys_rst}, {31'h0, is_rst});
            acc[bit_pos[i]] = 1'b1;
            wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
            check("flags", q, acc);
            check("sticky", q & acc, acc);
        end
        @(posedge clk_in);
        pin_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        pin_n <= 1'b1;
        repeat (4) @(posedge clk_in);
        wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
        check("pin flag", q, acc | 32'h0000_0080);
        // Second power-on in mid-run
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
        check("por again", q, 32'h0000_0003);
        // A clearing write racing a brown-out event loses to the event
        ev <= 8'h80;
        wb(1'b1, 8'h00, 4'h3, 32'h0000_0000);
        ev <= 8'h00;
        wb(1'b0, 8'h00, 4'hF, 32'h0000_0000);
        check("set wins", q, 32'h0000_0002);
        stop_test();
    end
endmodule

`default_nettype wire
